// file: hdl/pin_cfg_params.svh
// constants for the three-pin configuration block
`ifndef PIN_CFG_PARAMS_SVH
`define PIN_CFG_PARAMS_SVH

// register word indices; byte address is four times the index
`define PIN3_CFG_IDX 8'h63
`define PIN4_CFG_IDX 8'h64
`define PIN5_CFG_IDX 8'h65

// field positions inside each 8-bit register
`define FLD_SET 0
`define FLD_LEVEL 1
`define FLD_DIR 2
`define FLD_PDEN 3
`define FLD_DEB 4
`define FLD_SEL_LO 5
`define FLD_SEL_HI 6

// reset values
`define RST_SET 1'b0
`define RST_DIR 1'b0
`define RST_PDEN 1'b1
`define RST_DEB 1'b0
`define RST_SEL 2'h0
`define RST_LEVEL 1'b1

// timing, clock period and filter figures
`define CLK_PERIOD_PS 5000
`define FAST_TICK_PS 30500000
`define FAST_WINDOW_PS 91500000
`define SLOW_TICK_MS 50
`define SLOW_WINDOW_MS 150
`define PS_PER_MS 1000000000

// ahb encodings
`define HTRANS_NONSEQ_BIT 1
`define HRESP_OKAY 1'b0

`endif

// file: hdl/pin_cfg_pkg.sv
// types shared by the pin configuration block
package pin_cfg_pkg;
    // pad driver source for the third pin
    typedef enum logic [1:0] {
        SRC_SET = 2'h0,
        SRC_SECOND_LED_PULSE_OUTPUT = 2'h1,
        SRC_PWM = 2'h2,
        SRC_SPARE = 2'h3
    } out_src_t;
endpackage : pin_cfg_pkg

// file: hdl/pin_filter.sv
// input filter for one pad: level changes after a full window of agreeing samples
`timescale 1ns/1ps
`default_nettype none
`include "pin_cfg_params.svh"
module pin_filter
    import pin_cfg_pkg::*;
#(
    parameter int SAMPLES = 3
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic raw_in,
    input wire logic fast_tick_in,
    input wire logic slow_tick_in,
    input wire logic slow_sel_in,
    output var logic level_out
);
    logic level_reg;
    logic [1:0] agree_reg;
    logic [1:0] agree_next;
    wire tick = slow_sel_in ? slow_tick_in : fast_tick_in;
    wire differs = raw_in != level_reg;
    wire window_done = differs && (agree_reg == 2'(SAMPLES - 1));

    // count consecutive differing samples; a matching sample restarts the window
    assign agree_next = (!differs || window_done) ? 2'h0 : agree_reg + 2'h1;

    // sample only on the selected tick so glitches between ticks are ignored
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            level_reg <= `RST_LEVEL;
            agree_reg <= 2'h0;
        end
        else if (tick)
        begin
            agree_reg <= agree_next;
            if (window_done)
                level_reg <= raw_in;
        end
    end

    assign level_out = level_reg;

    AST_FAST_WINDOW: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ($changed(level_reg) && !$past(slow_sel_in)) |-> $past(fast_tick_in)
            && $past(agree_reg) == 2'(SAMPLES - 1))
        else $error("fast filter changed level without a full window");

    AST_SLOW_WINDOW: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        ($changed(level_reg) && $past(slow_sel_in)) |-> $past(slow_tick_in)
            && $past(raw_in) == level_reg)
        else $error("slow filter changed level off its tick");
endmodule : pin_filter
`default_nettype wire

// file: hdl/pin_cfg_top.sv
// configuration, filtering and pad drive for three general-purpose pins
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pin_cfg_params.svh"
module pin_cfg_top
    import pin_cfg_pkg::*;
#(
    parameter int FAST_TICK_CYC = `FAST_TICK_PS / `CLK_PERIOD_PS,
    parameter int SLOW_TICK_CYC = `SLOW_TICK_MS * (`PS_PER_MS / `CLK_PERIOD_PS)
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output var logic [31:0] hrdata_out,
    output var logic hreadyout_out,
    output var logic hresp_out,
    input wire logic [2:0] pad_in,
    input wire logic second_led_pulse_output_in,
    input wire logic pwm_in,
    output var logic [2:0] pad_out,
    output var logic [2:0] pad_oe_out,
    output var logic [2:0] pad_pulldown_enable_out,
    output var logic [2:0] pad_level_out
);
    // both windows span the same number of samples, so one filter count serves
    localparam int SAMPLES = `FAST_WINDOW_PS / `FAST_TICK_PS;

    // per-pin register fields; selector exists only on the third pin (index 0)
    logic [2:0] set_reg;
    logic [2:0] dir_reg;
    logic [2:0] pden_reg;
    logic [2:0] deb_reg;
    out_src_t sel_reg;
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic [2:0] level;
    logic [2:0] drive_next;
    logic [2:0] drive_reg;
    logic [2:0] oe_reg;
    logic [2:0] pden_out_reg;
    logic [31:0] fast_cnt_reg;
    logic [31:0] slow_cnt_reg;
    logic wr_pend_reg;
    logic [2:0] wr_hit_reg;
    logic [31:0] rdata_reg;
    logic [7:0] rd_byte [3];
    logic [7:0] wbyte;

    // address phase decode; offsets are word indices, hence the shift
    wire addr_upper_zero = haddr_in[31:10] == 22'h0;
    wire [2:0] addr_hit;
    assign addr_hit[0] = addr_upper_zero && haddr_in[9:2] == `PIN3_CFG_IDX;
    assign addr_hit[1] = addr_upper_zero && haddr_in[9:2] == `PIN4_CFG_IDX;
    assign addr_hit[2] = addr_upper_zero && haddr_in[9:2] == `PIN5_CFG_IDX;
    wire accept = hsel_in && htrans_in[`HTRANS_NONSEQ_BIT] && hready_in;
    wire rd_take = accept && !hwrite_in;
    wire [31:0] rd_sel = addr_hit[0] ? {24'h0, rd_byte[0]} :
                         addr_hit[1] ? {24'h0, rd_byte[1]} :
                         addr_hit[2] ? {24'h0, rd_byte[2]} : 32'h0;
    assign wbyte = hwdata_in[7:0];

    // sample tick prescalers shared by all three filters
    wire fast_tick = fast_cnt_reg == 32'(FAST_TICK_CYC - 1);
    wire slow_tick = slow_cnt_reg == 32'(SLOW_TICK_CYC - 1);

    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fast_cnt_reg <= 32'h0;
            slow_cnt_reg <= 32'h0;
        end
        else
        begin
            fast_cnt_reg <= fast_tick ? 32'h0 : fast_cnt_reg + 32'h1;
            slow_cnt_reg <= slow_tick ? 32'h0 : slow_cnt_reg + 32'h1;
        end
    end

    // pads are asynchronous to this clock: two flops before anything looks
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            // match the filter's reset level so no false change follows reset
            sync1_reg <= {3{`RST_LEVEL}};
            sync2_reg <= {3{`RST_LEVEL}};
        end
        else
        begin
            sync1_reg <= pad_in;
            sync2_reg <= sync1_reg;
        end
    end

    // bus handshake: zero wait states, write data lands in the data phase
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_pend_reg <= 1'b0;
            wr_hit_reg <= 3'h0;
            rdata_reg <= 32'h0;
        end
        else
        begin
            wr_pend_reg <= accept && hwrite_in;
            wr_hit_reg <= addr_hit;
            if (rd_take)
                rdata_reg <= rd_sel;
        end
    end

    // third pin selector; reserved bit 7 is not stored
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            sel_reg <= out_src_t'(`RST_SEL);
        else if (wr_pend_reg && wr_hit_reg[0])
            sel_reg <= out_src_t'(wbyte[`FLD_SEL_HI:`FLD_SEL_LO]);
    end

    genvar i;
    generate
        for (i = 0; i < 3; i++)
        begin : g_pin
            // stored fields
            // bit 1 is not stored, so a write to it has no effect
            always_ff @(posedge sys_clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    set_reg[i] <= `RST_SET;
                    dir_reg[i] <= `RST_DIR;
                    pden_reg[i] <= `RST_PDEN;
                    deb_reg[i] <= `RST_DEB;
                end
                else if (wr_pend_reg && wr_hit_reg[i])
                begin
                    set_reg[i] <= wbyte[`FLD_SET];
                    dir_reg[i] <= wbyte[`FLD_DIR];
                    pden_reg[i] <= wbyte[`FLD_PDEN];
                    deb_reg[i] <= wbyte[`FLD_DEB];
                end
            end

            pin_filter #(
                .SAMPLES(SAMPLES)
            ) u_filter (
                .sys_clk_in(sys_clk_in),
                .rst_n_in(rst_n_in),
                .raw_in(sync2_reg[i]),
                .fast_tick_in(fast_tick),
                .slow_tick_in(slow_tick),
                .slow_sel_in(deb_reg[i]),
                .level_out(level[i])
            );

            assign rd_byte[i] = {1'b0,
                                 (i == 0) ? sel_reg : out_src_t'(2'h0),
                                 deb_reg[i], pden_reg[i], dir_reg[i],
                                 level[i], set_reg[i]};
        end
    endgenerate

    // source choice
    // pins four and five have no selector and always drive the stored value
    assign drive_next[0] = !dir_reg[0] ? 1'b0 :
                           (sel_reg == SRC_SECOND_LED_PULSE_OUTPUT) ? second_led_pulse_output_in :
                           (sel_reg == SRC_PWM) ? pwm_in : set_reg[0];
    assign drive_next[2:1] = dir_reg[2:1] & set_reg[2:1];

    // pad controls leave through flops so the pads never see decode glitches
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            drive_reg <= {3{`RST_SET}};
            oe_reg <= {3{`RST_DIR}};
            pden_out_reg <= {3{`RST_PDEN}};
        end
        else
        begin
            drive_reg <= drive_next;
            oe_reg <= dir_reg;
            pden_out_reg <= pden_reg;
        end
    end

    assign pad_out = drive_reg;
    assign pad_oe_out = oe_reg;
    assign pad_pulldown_enable_out = pden_out_reg;
    assign pad_level_out = level;
    assign hrdata_out = rdata_reg;
    assign hreadyout_out = 1'b1;
    assign hresp_out = `HRESP_OKAY;

    AST_THIRD_PIN_SOURCE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (dir_reg[0] && sel_reg == SRC_SECOND_LED_PULSE_OUTPUT) |=> pad_out[0] == $past(second_led_pulse_output_in))
        else $error("third pin does not follow the led pulse source");

    AST_PWM_SOURCE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (dir_reg[0] && sel_reg == SRC_PWM) |=> pad_out[0] == $past(pwm_in))
        else $error("third pin does not follow the pwm source");

    AST_PULLDOWN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (wr_pend_reg && wr_hit_reg[1]) |=> ##1
            pad_pulldown_enable_out[1] == $past(wbyte[`FLD_PDEN], 2))
        else $error("pulldown does not follow its bit");

    AST_DIRECTION: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !dir_reg[2] |=> !pad_oe_out[2])
        else $error("pad driven while configured as input");

    AST_LEVEL_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (rd_take && addr_hit[2]) |=> hrdata_out[`FLD_LEVEL] == $past(level[2]))
        else $error("readback does not show the pad level");

    AST_STORED_DRIVE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (dir_reg[1] && set_reg[1]) ##1 (dir_reg[1] && set_reg[1]) |-> pad_out[1] && pad_oe_out[1])
        else $error("output pin does not drive its stored value");

    AST_SPARE_CODE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        (dir_reg[0] && sel_reg == SRC_SPARE) |=> pad_out[0] == $past(set_reg[0]))
        else $error("selector 11 does not fall back to the stored value");
endmodule : pin_cfg_top
`default_nettype wire

// file: test/pad_partner.sv
// model of the external circuits on the three pads
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
    input wire logic clk_in,
    input wire logic [2:0] drive_in,
    input wire logic [2:0] oe_in,
    input wire logic [2:0] pull_in,
    input wire logic [2:0] ext_en_in,
    input wire logic [2:0] ext_val_in,
    output var logic [2:0] level_out
);
    logic [2:0] float_reg = 3'h2;
    // a pad nobody holds wanders, so a stale level never passes
    always_ff @(posedge clk_in)
        float_reg <= ~float_reg;
    always_comb
        for (int i = 0; i < 3; i++)
            level_out[i] = oe_in[i] ? drive_in[i] : ext_en_in[i] ? ext_val_in[i] :
                pull_in[i] ? 1'b0 : float_reg[i];
endmodule : pad_partner
`default_nettype wire

// file: test/pin_cfg_top_bench.sv
// self-checking bench for the three-pin configuration block
`timescale 1ns/1ps
`default_nettype none
module pin_cfg_top_bench;
    logic sys_clk_in, rst_n_in, hsel, hwrite, led, pwm;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata;
    logic [2:0] ext_en, ext_val;
    wire logic [31:0] hrdata;
    wire logic hrdy, hresp;
    wire logic [2:0] pad_in, pad_out, pad_oe, pad_pd, pad_lvl;
    int n_mismatch, num_checks;
    // small tick counts keep filter windows short
    pin_cfg_top #(.FAST_TICK_CYC(4), .SLOW_TICK_CYC(8)) dut_u (.sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hrdy), .hwdata_in(hwdata),
        .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp), .pad_in(pad_in),
        .second_led_pulse_output_in(led), .pwm_in(pwm), .pad_out(pad_out),
        .pad_oe_out(pad_oe), .pad_pulldown_enable_out(pad_pd), .pad_level_out(pad_lvl));
    pad_partner pad_u (.clk_in(sys_clk_in), .drive_in(pad_out), .oe_in(pad_oe),
        .pull_in(pad_pd), .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(pad_in));
    // 200 MHz clock
    initial
    begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t register got %h want %h", $time, got, exp);
        end
    endtask : chk32
    task automatic chk3(input logic [2:0] got, input logic [2:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t pad bits got %b want %b", $time, got, exp);
        end
    endtask : chk3
    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int i;
        i = 0;
        @(posedge sys_clk_in);
        while (hrdy !== 1'b1)
        begin
            i++;
            if (i > 50)
            begin
                n_mismatch++;
                $display("[FAIL] %0t bus wait ran out", $time);
                wrap_up();
            end
            @(posedge sys_clk_in);
        end
    endtask : wait_ready
    // one single word transfer; byte address is four times the index
    task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_ready();
        rd = hrdata;
    endtask : bus
    // write then one idle cycle, since reads are not forwarded
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(idx, 1'b1, wd, d);
        @(posedge sys_clk_in);
    endtask : wr
    task automatic rd(input logic [7:0] idx, output logic [31:0] d);
        bus(idx, 1'b0, 8'h0, d);
    endtask : rd
    task automatic t_reset();
        logic [31:0] d;
        chk3(pad_pd, 3'h7);
        chk3(pad_oe, 3'h0);
        chk3(pad_out, 3'h0);
        for (int i = 8'h63; i < 8'h67; i++)
        begin
            rd(i[7:0], d);
            chk32(d, i == 8'h66 ? 32'h0 : 32'h0a);
        end
        chk3({2'h0, hresp}, 3'h0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_fields();
        logic [31:0] d;
        for (int i = 8'h63; i < 8'h67; i++)
            wr(i[7:0], 8'hf5);
        chk3(pad_oe, 3'h7);
        chk3(pad_out, 3'h7);
        chk3(pad_pd, 3'h0);
        for (int i = 8'h63; i < 8'h67; i++)
        begin
            rd(i[7:0], d);
            chk32(d, i == 8'h63 ? 32'h77 : i == 8'h66 ? 32'h0 : 32'h17);
        end
        for (int i = 8'h63; i < 8'h66; i++)
            wr(i[7:0], 8'h08);
        // pad controls of the last write launch at the edge wr returns on
        @(posedge sys_clk_in);
        chk3(pad_oe, 3'h0);
        chk3(pad_out, 3'h0);
        $display("field test done");
    endtask : t_fields
    task automatic t_source();
        logic e;
        for (int c = 0; c < 32; c++)
        begin
            wr(8'h63, {1'b0, c[4:3], 4'h2, c[0]});
            led <= c[1];
            pwm <= c[2];
            repeat (2) @(posedge sys_clk_in);
            e = c[4:3] == 2'h1 ? c[1] : c[4:3] == 2'h2 ? c[2] : c[0];
            chk3(pad_out, {2'h0, e});
            chk3(pad_oe, 3'h1);
        end
        wr(8'h63, 8'h08);
        $display("source test done");
    endtask : t_source
    task automatic t_filter();
        logic [31:0] d;
        ext_en[2] <= 1'b0;
        repeat (40) @(posedge sys_clk_in);
        chk3(pad_lvl, 3'h3);
        rd(8'h65, d);
        chk32(d, 32'h08);
        ext_en[2] <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        ext_en[2] <= 1'b0;
        repeat (40) @(posedge sys_clk_in);
        chk3(pad_lvl, 3'h3);
        wr(8'h65, 8'h18);
        ext_en[2] <= 1'b1;
        repeat (16) @(posedge sys_clk_in);
        chk3(pad_lvl, 3'h3);
        repeat (40) @(posedge sys_clk_in);
        chk3(pad_lvl, 3'h7);
        rd(8'h65, d);
        chk32(d, 32'h1a);
        $display("filter test done");
    endtask : t_filter
    // main sequence
    initial
    begin
        rst_n_in = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        led = 1'b0;
        pwm = 1'b0;
        ext_en = 3'h7;
        ext_val = 3'h7;
        n_mismatch = 0;
        num_checks = 0;
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        @(posedge sys_clk_in);
        t_reset();
        t_fields();
        t_source();
        t_filter();
        wrap_up();
    end
endmodule : pin_cfg_top_bench
`default_nettype wire
